// File: sysctl_consts.vh
// Constants for the system reset, watchdog, wakeup and periodic timer control block.
//
// Operation
// - After any reset, fetch starts at address 3FFD; control registers take initial values, except the reset pin enable, which only power-on reset clears.
// - During reset, peripherals are disabled and pins become plain inputs, no pulls.
// - Seven reset sources; all except debug-forced reset have a status flag.
// - Debug-forced reset clears every flag in the reset-source register.
// - Any write to reset-source register restarts the watchdog; flags stay unchanged.
// - Watchdog counts 1 kHz ticks, overflows at 32 or 256; defaults enabled, long.
// - Enabled watchdog overflow forces a system reset; software must restart it in time.
// - First write to the system options register after reset restarts the watchdog.
// - In background debug mode the watchdog counter holds.
// - Stop entry clears the watchdog counter; counting resumes from zero on exit.
// - No vectored interrupts; enabled requests only wake the processor from wait or stop.
// - A disabled module request cannot wake, but its event flag still sets.
// - Pending summary bits are read-only; each clears once its own module flag clears.
// - Low-voltage detector runs only when enabled; off in stop unless stop-enable set.
// - Power-on reset sets power-on and low-voltage flags; held until voltage recovers.
// - With low-voltage reset enabled, low voltage resets and holds; sets low-voltage flag.
// - Detector and interrupt enabled, reset disabled: low voltage sets flag and requests wakeup.
// - Periodic timer clocked by 1 kHz or external reference, runs in run, wait, stop.
// - Three-bit period field picks one of seven periods; zero disables the timer.
// - Periodic timer has read-only flag, write-only acknowledge, and a wakeup mask enable.
// - Acknowledge write of 1 clears the timer flag; 0 does nothing; reads zero.
// - On other resets each flag is set if its source was active, else cleared.
// - Watchdog enable and timeout select are write-once after reset.
`ifndef SYSCTL_CONSTS_VH
`define SYSCTL_CONSTS_VH

// Reset start address and jump opcode.
`define RESET_START_ADDR 14'h3FFD
`define JUMP_OPCODE 8'hBC

// Reset-source register bit positions.
`define RSR_POR 7
`define RSR_PIN 6
`define RSR_WDOG 5
`define RSR_ILLEGAL_OPCODE_RESET 4
`define RSR_ILLEGAL_ADDRESS_RESET 3
`define RSR_LVD 1

// System options register bit positions of the watchdog pair and reset pin enable.
`define OPT_WDOG_EN 7
`define OPT_WDOG_LONG 6
`define OPT_RST_PIN 0

// Watchdog overflow counts in 1 kHz ticks.
`define WDOG_W 8
`define WDOG_SHORT_MAX 8'h1F
`define WDOG_LONG_MAX 8'hFF

// Periodic timer prescaler: period code n selects 2^(n+2) ticks.
`define PT_W 10
`define PT_BASE_SHIFT 2

// Bus clock cycles per 1 kHz tick at 100 MHz.
`define TICK_PERIOD_NS 1000000
`define CLK_PERIOD_NS 10
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_W 17

// Number of wakeup sources in the pending summary.
`define NUM_WAKE 7

`endif

// File: sync2.v
// Two flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Data
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);

  reg [W-1:0] meta_q;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule // sync2

// File: tick_gen.v
// Free-running 1 kHz tick generator derived from the bus clock.
`timescale 1ns/1ps
`include "sysctl_consts.vh"
module tick_gen (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Tick
  output reg tick_out
);

  // The full-width count is cut to the counter width on purpose.
  localparam [31:0] LAST_W = `TICK_CYCLES - 1;
  localparam [`TICK_W-1:0] LAST = LAST_W[`TICK_W-1:0];
  reg [`TICK_W-1:0] cnt_q;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= {`TICK_W{1'b0}};
      tick_out <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= {`TICK_W{1'b0}};
      tick_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule // tick_gen

// File: sysctl_top.v
// System reset collection, watchdog, low-voltage, wakeup gating and periodic wakeup timer.
`timescale 1ns/1ps
`include "sysctl_consts.vh"
module sysctl_top (
  // Clock and reset (power-on reset, active low)
  input wire clk_in,
  input wire nrst_in,
  // Asynchronous reset source, supply monitor and external reference clock
  input wire reset_pin_n_in,
  input wire low_voltage_in,
  input wire ext_ref_clk_in,
  // Same-clock reset requests from the core and debug controller
  input wire illegal_opcode_reset_in,
  input wire illegal_address_reset_in,
  input wire debug_forced_reset_command_in,
  // Processor state
  input wire background_debug_in,
  input wire stop_mode_in,
  input wire wait_mode_in,
  // Register writes: reset-source address strobe, system options
  input wire reset_source_write_in,
  input wire system_options_write_in,
  input wire [7:0] system_options_wdata_in,
  // Power monitor control
  input wire low_voltage_detector_enable_in,
  input wire low_voltage_stop_enable_in,
  input wire low_voltage_reset_enable_in,
  input wire low_voltage_irq_enable_in,
  input wire low_voltage_flag_ack_in,
  // Periodic timer control
  input wire periodic_timer_write_in,
  input wire periodic_timer_clock_select_in,
  input wire periodic_timer_irq_enable_in,
  input wire [2:0] periodic_timer_period_in,
  input wire periodic_timer_acknowledge_in,
  // Module wakeup requests (flags and enables), bit 0 is the periodic timer
  input wire [`NUM_WAKE-1:0] module_flag_in,
  input wire [`NUM_WAKE-1:0] module_irq_enable_in,
  // System outputs
  output reg system_reset_out,
  output reg [13:0] reset_fetch_addr_out,
  output reg peripherals_disable_out,
  output reg pins_input_only_out,
  output reg [7:0] reset_source_register_out,
  output reg [7:0] system_options_register_out,
  output reg [`WDOG_W-1:0] watchdog_count_out,
  output reg low_voltage_detector_on_out,
  output reg low_voltage_flag_out,
  output reg periodic_timer_flag_out,
  output reg periodic_timer_acknowledge_out,
  output reg [`NUM_WAKE-1:0] pending_wakeup_summary_out,
  output reg wakeup_out
);

  // ------------------------------------------------------------------
  // Reset release and input synchronisation
  // ------------------------------------------------------------------
  reg rst_m_q;
  reg rst_n_q;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  wire [2:0] async_s;
  sync2 #(.W(3)) u_sync (
    .clk_in(clk_in),
    .nrst_in(rst_n_q),
    .d_in({~reset_pin_n_in, low_voltage_in, ext_ref_clk_in}),
    .q_out(async_s)
  );
  wire pin_rst_s = async_s[2];
  wire lv_s = async_s[1];
  wire ext_s = async_s[0];

  wire tick;
  tick_gen u_tick (
    .clk_in(clk_in),
    .nrst_in(rst_n_q),
    .tick_out(tick)
  );

  // ------------------------------------------------------------------
  // System options register, write-once
  // ------------------------------------------------------------------
  reg opt_locked_q;
  reg wd_en_q;
  reg wd_long_q;
  reg rst_pin_en_q;
  wire opt_first_wr = system_options_write_in && !opt_locked_q && !system_reset_out;

  // ------------------------------------------------------------------
  // Low-voltage detector
  // ------------------------------------------------------------------
  // Detector runs when enabled; in stop it needs the stop enable too.
  wire lvd_on = low_voltage_detector_enable_in &&
                (!stop_mode_in || low_voltage_stop_enable_in);
  wire lv_rst_req = lvd_on && low_voltage_reset_enable_in && lv_s;
  wire lv_irq_evt = lvd_on && low_voltage_irq_enable_in &&
                    !low_voltage_reset_enable_in && lv_s;
  reg lv_flag_q;

  // ------------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------------
  reg [`WDOG_W-1:0] wd_cnt_q;
  wire [`WDOG_W-1:0] wd_max = wd_long_q ? `WDOG_LONG_MAX : `WDOG_SHORT_MAX;
  wire wd_overflow = wd_en_q && tick && (wd_cnt_q == wd_max) &&
                     !background_debug_in && !stop_mode_in;

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wd_cnt_q <= {`WDOG_W{1'b0}};
    end else if (system_reset_out) begin
      wd_cnt_q <= {`WDOG_W{1'b0}};
    end else if (reset_source_write_in || opt_first_wr) begin
      wd_cnt_q <= {`WDOG_W{1'b0}};
    end else if (stop_mode_in) begin
      wd_cnt_q <= {`WDOG_W{1'b0}};
    end else if (background_debug_in || !wd_en_q) begin
      wd_cnt_q <= wd_cnt_q;
    end else if (tick) begin
      wd_cnt_q <= (wd_cnt_q == wd_max) ? {`WDOG_W{1'b0}} : wd_cnt_q + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Reset collection and sequencing
  // ------------------------------------------------------------------
  // Requests captured while reset is asserted; flags are written on release.
  reg por_q;
  reg held_lv_q;
  reg [4:0] src_q; // pin, watchdog, opcode, address, low voltage
  reg dbg_q;
  wire pin_req = pin_rst_s && rst_pin_en_q;
  wire any_req = pin_req || wd_overflow || illegal_opcode_reset_in ||
                 illegal_address_reset_in || debug_forced_reset_command_in ||
                 lv_rst_req;
  // Supply must recover before leaving power-on or low-voltage reset.
  wire hold = lv_s && (por_q || held_lv_q);

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      system_reset_out <= 1'b1;
      por_q <= 1'b1;
      held_lv_q <= 1'b0;
      src_q <= 5'h00;
      dbg_q <= 1'b0;
      reset_source_register_out <= 8'h00;
    end else if (system_reset_out) begin
      src_q <= src_q | {pin_req, 1'b0, illegal_opcode_reset_in,
                        illegal_address_reset_in, lv_rst_req};
      dbg_q <= dbg_q | debug_forced_reset_command_in;
      if (lv_rst_req) begin
        held_lv_q <= 1'b1;
      end
      if (!hold && !any_req) begin
        system_reset_out <= 1'b0;
        por_q <= 1'b0;
        held_lv_q <= 1'b0;
        src_q <= 5'h00;
        dbg_q <= 1'b0;
        reset_source_register_out <= 8'h00;
        if (por_q) begin
          reset_source_register_out[`RSR_POR] <= 1'b1;
          reset_source_register_out[`RSR_LVD] <= 1'b1;
        end else if (!dbg_q) begin
          reset_source_register_out[`RSR_PIN] <= src_q[4];
          reset_source_register_out[`RSR_WDOG] <= src_q[3];
          reset_source_register_out[`RSR_ILLEGAL_OPCODE_RESET] <= src_q[2];
          reset_source_register_out[`RSR_ILLEGAL_ADDRESS_RESET] <= src_q[1];
          reset_source_register_out[`RSR_LVD] <= src_q[0] | held_lv_q;
        end
      end
    end else if (any_req) begin
      system_reset_out <= 1'b1;
      src_q <= {pin_req, wd_overflow, illegal_opcode_reset_in,
                illegal_address_reset_in, lv_rst_req};
      held_lv_q <= lv_rst_req;
      dbg_q <= debug_forced_reset_command_in;
    end
  end

  // Watchdog pair resets to enabled/long; the pin enable survives non-power-on resets.
  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      opt_locked_q <= 1'b0;
      wd_en_q <= 1'b1;
      wd_long_q <= 1'b1;
      rst_pin_en_q <= 1'b0;
    end else if (system_reset_out) begin
      opt_locked_q <= 1'b0;
      wd_en_q <= 1'b1;
      wd_long_q <= 1'b1;
    end else if (opt_first_wr) begin
      opt_locked_q <= 1'b1;
      wd_en_q <= system_options_wdata_in[`OPT_WDOG_EN];
      wd_long_q <= system_options_wdata_in[`OPT_WDOG_LONG];
      rst_pin_en_q <= system_options_wdata_in[`OPT_RST_PIN];
    end
  end

  // ------------------------------------------------------------------
  // Periodic wakeup timer
  // ------------------------------------------------------------------
  reg ext_d_q;
  wire ext_tick = ext_s && !ext_d_q;
  wire pt_tick = periodic_timer_clock_select_in ? ext_tick : tick;
  reg [`PT_W-1:0] pt_cnt_q;
  wire [`PT_W-1:0] pt_last = (({{(`PT_W-1){1'b0}}, 1'b1}) <<
                              (periodic_timer_period_in + `PT_BASE_SHIFT)) - 1'b1;
  wire pt_expire = (periodic_timer_period_in != 3'h0) && pt_tick && (pt_cnt_q == pt_last);
  wire pt_ack = periodic_timer_write_in && periodic_timer_acknowledge_in;

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ext_d_q <= 1'b0;
      pt_cnt_q <= {`PT_W{1'b0}};
      periodic_timer_flag_out <= 1'b0;
      periodic_timer_acknowledge_out <= 1'b0;
    end else begin
      ext_d_q <= ext_s;
      periodic_timer_acknowledge_out <= 1'b0;
      if (system_reset_out || periodic_timer_period_in == 3'h0) begin
        pt_cnt_q <= {`PT_W{1'b0}};
      end else if (pt_tick) begin
        pt_cnt_q <= pt_expire ? {`PT_W{1'b0}} : pt_cnt_q + 1'b1;
      end
      if (system_reset_out) begin
        periodic_timer_flag_out <= 1'b0;
      end else if (pt_expire) begin
        periodic_timer_flag_out <= 1'b1;
      end else if (pt_ack) begin
        periodic_timer_flag_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Low-voltage flag, wakeup gating and outputs
  // ------------------------------------------------------------------
  wire [`NUM_WAKE-1:0] flags = {module_flag_in[`NUM_WAKE-1:1], periodic_timer_flag_out};
  wire [`NUM_WAKE-1:0] enables = {module_irq_enable_in[`NUM_WAKE-1:1],
                                  periodic_timer_irq_enable_in};

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lv_flag_q <= 1'b0;
      low_voltage_flag_out <= 1'b0;
      low_voltage_detector_on_out <= 1'b0;
      pending_wakeup_summary_out <= {`NUM_WAKE{1'b0}};
      wakeup_out <= 1'b0;
      reset_fetch_addr_out <= `RESET_START_ADDR;
      peripherals_disable_out <= 1'b1;
      pins_input_only_out <= 1'b1;
      system_options_register_out <= 8'h00;
      watchdog_count_out <= {`WDOG_W{1'b0}};
    end else begin
      if (system_reset_out) begin
        lv_flag_q <= 1'b0;
      end else if (lv_irq_evt) begin
        lv_flag_q <= 1'b1;
      end else if (low_voltage_flag_ack_in) begin
        lv_flag_q <= 1'b0;
      end
      low_voltage_flag_out <= lv_flag_q;
      low_voltage_detector_on_out <= lvd_on;
      // Flags show outside system reset; enables only gate wakeup, no vector dispatch.
      pending_wakeup_summary_out <= system_reset_out ? {`NUM_WAKE{1'b0}} : flags;
      wakeup_out <= !system_reset_out && (wait_mode_in || stop_mode_in) &&
                    ((|(flags & enables)) || (lv_flag_q && low_voltage_irq_enable_in));
      reset_fetch_addr_out <= `RESET_START_ADDR;
      peripherals_disable_out <= system_reset_out;
      pins_input_only_out <= system_reset_out;
      system_options_register_out <= {wd_en_q, wd_long_q, 5'h00, rst_pin_en_q};
      watchdog_count_out <= wd_cnt_q;
    end
  end

endmodule // sysctl_top

// File: sysctl_properties.sv
// Concurrent checks on the ports of the system control block.
`timescale 1ns/1ps
`include "sysctl_consts.vh"
module sysctl_properties (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Watched inputs
  input wire low_voltage_in,
  input wire debug_forced_reset_command_in,
  input wire background_debug_in,
  input wire stop_mode_in,
  input wire wait_mode_in,
  input wire reset_source_write_in,
  input wire system_options_write_in,
  input wire low_voltage_detector_enable_in,
  input wire low_voltage_stop_enable_in,
  input wire low_voltage_reset_enable_in,
  input wire low_voltage_irq_enable_in,
  input wire periodic_timer_irq_enable_in,
  input wire [2:0] periodic_timer_period_in,
  input wire [`NUM_WAKE-1:0] module_flag_in,
  input wire [`NUM_WAKE-1:0] module_irq_enable_in,
  // Watched outputs
  input wire system_reset_out,
  input wire [13:0] reset_fetch_addr_out,
  input wire peripherals_disable_out,
  input wire pins_input_only_out,
  input wire [`WDOG_W-1:0] watchdog_count_out,
  input wire low_voltage_detector_on_out,
  input wire periodic_timer_flag_out,
  input wire periodic_timer_acknowledge_out,
  input wire [`NUM_WAKE-1:0] pending_wakeup_summary_out,
  input wire wakeup_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_fetch_start: assert property (reset_fetch_addr_out == 14'h3FFD)
    else $error("fetch start address wrong");
  a_reset_quiets: assert property (system_reset_out |=> peripherals_disable_out && pins_input_only_out)
    else $error("peripherals or pins active in reset");
  a_debug_resets: assert property (debug_forced_reset_command_in |=> system_reset_out)
    else $error("debug reset not taken");
  a_wdog_restart: assert property (reset_source_write_in && !system_reset_out |-> ##2 watchdog_count_out == 8'h00)
    else $error("watchdog not restarted");
  a_debug_hold: assert property ((background_debug_in && !reset_source_write_in && !stop_mode_in
    && !system_options_write_in
    && !system_reset_out) [*3] |-> $stable(watchdog_count_out))
    else $error("watchdog moved in debug");
  a_stop_clear: assert property ($rose(stop_mode_in) |-> ##2 watchdog_count_out == 8'h00)
    else $error("watchdog not cleared on stop");
  a_wake_gated: assert property (!wait_mode_in && !stop_mode_in |=> !wakeup_out)
    else $error("wakeup while running");
  a_wake_masked: assert property (module_irq_enable_in[`NUM_WAKE-1:1] == 0 && !periodic_timer_irq_enable_in
    && !low_voltage_irq_enable_in |=> !wakeup_out)
    else $error("masked request woke");
  a_summary_clear: assert property (module_flag_in[`NUM_WAKE-1:1] == 0
    |=> pending_wakeup_summary_out[`NUM_WAKE-1:1] == 0)
    else $error("summary bit stuck");
  a_lvd_gated: assert property ((!low_voltage_detector_enable_in || stop_mode_in && !low_voltage_stop_enable_in)
    [*2] |=> !low_voltage_detector_on_out)
    else $error("detector on when off");
  a_lvd_reset: assert property (low_voltage_reset_enable_in && low_voltage_detector_enable_in && low_voltage_in
    && (!stop_mode_in || low_voltage_stop_enable_in) |-> ##[1:5] system_reset_out)
    else $error("low voltage did not reset");
  a_period_off: assert property ($rose(periodic_timer_flag_out) |-> $past(periodic_timer_period_in) != 3'h0)
    else $error("timer flag while disabled");
  a_ack_zero: assert property (periodic_timer_acknowledge_out == 1'b0)
    else $error("acknowledge reads one");
endmodule // sysctl_properties

bind sysctl_top sysctl_properties u_props (
  .clk_in(clk_in), .nrst_in(nrst_in), .low_voltage_in(low_voltage_in), .background_debug_in(background_debug_in),
  .debug_forced_reset_command_in(debug_forced_reset_command_in), .stop_mode_in(stop_mode_in),
  .wait_mode_in(wait_mode_in), .reset_source_write_in(reset_source_write_in),
  .system_options_write_in(system_options_write_in),
  .low_voltage_detector_enable_in(low_voltage_detector_enable_in),
  .low_voltage_stop_enable_in(low_voltage_stop_enable_in), .low_voltage_reset_enable_in(low_voltage_reset_enable_in),
  .low_voltage_irq_enable_in(low_voltage_irq_enable_in), .periodic_timer_irq_enable_in(periodic_timer_irq_enable_in),
  .periodic_timer_period_in(periodic_timer_period_in), .module_flag_in(module_flag_in),
  .module_irq_enable_in(module_irq_enable_in), .system_reset_out(system_reset_out),
  .reset_fetch_addr_out(reset_fetch_addr_out), .peripherals_disable_out(peripherals_disable_out),
  .pins_input_only_out(pins_input_only_out), .watchdog_count_out(watchdog_count_out),
  .low_voltage_detector_on_out(low_voltage_detector_on_out), .periodic_timer_flag_out(periodic_timer_flag_out),
  .periodic_timer_acknowledge_out(periodic_timer_acknowledge_out),
  .pending_wakeup_summary_out(pending_wakeup_summary_out), .wakeup_out(wakeup_out)
);

// File: supply_model.sv
// Supply monitor and external reference model.
`timescale 1ns/1ps
module supply_model (
  // Clock
  input wire clk_in,
  // Test controls
  input wire brownout_in,
  input wire ref_run_in,
  // Supply level and reference
  output reg low_voltage_out,
  output reg ext_ref_out
);
  reg [4:0] age_q;
  reg [1:0] div_q;
  // ----------------------------------------
  // Supply ramp and reference divider
  // ----------------------------------------
  initial begin
    age_q = 5'h00;
    div_q = 2'h0;
    low_voltage_out = 1'b1;
    ext_ref_out = 1'b0;
  end
  // The supply stays low for a while after power-up; the reference stands still unless running.
  always @(posedge clk_in) begin
    if (age_q != 5'h1F) age_q <= age_q + 5'h01;
    low_voltage_out <= (age_q < 5'h14) | brownout_in;
    div_q <= ref_run_in ? div_q + 2'h1 : 2'h0;
    if (ref_run_in && div_q == 2'h3) ext_ref_out <= ~ext_ref_out;
  end
endmodule // supply_model

// File: sysctl_top_tb.sv
// Self-checking testbench for the system control block.
`timescale 1ns/1ps
module sysctl_top_tb;
  reg clk_in, nrst_in, rp_n, illegal_opcode_reset, illegal_address_reset, dbgr, bdm, stp, wt, srw, sow, lde, lse, lre, lie, lack;
  reg ptw, pcs, pie, pack, brown, refrun;
  reg [7:0] sod;
  reg [2:0] per;
  reg [6:0] mf, me;
  wire sro, pd, pio, lon, lfl, ptf, pta, wk, lv, er;
  wire [13:0] fa;
  wire [7:0] rsr, sor, wc;
  wire [6:0] sum;
  // Application image bytes at the reset start address.
  reg [7:0] image [14'h3FFD:14'h3FFF];
  integer mismatches, total_checks, k, ecnt;
  supply_model u_sup (.clk_in(clk_in), .brownout_in(brown), .ref_run_in(refrun), .low_voltage_out(lv),
    .ext_ref_out(er));
  sysctl_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .reset_pin_n_in(rp_n), .low_voltage_in(lv),
    .ext_ref_clk_in(er), .illegal_opcode_reset_in(illegal_opcode_reset), .illegal_address_reset_in(illegal_address_reset),
    .debug_forced_reset_command_in(dbgr), .background_debug_in(bdm), .stop_mode_in(stp), .wait_mode_in(wt),
    .reset_source_write_in(srw), .system_options_write_in(sow), .system_options_wdata_in(sod),
    .low_voltage_detector_enable_in(lde), .low_voltage_stop_enable_in(lse), .low_voltage_reset_enable_in(lre),
    .low_voltage_irq_enable_in(lie), .low_voltage_flag_ack_in(lack), .periodic_timer_write_in(ptw),
    .periodic_timer_clock_select_in(pcs), .periodic_timer_irq_enable_in(pie), .periodic_timer_period_in(per),
    .periodic_timer_acknowledge_in(pack), .module_flag_in(mf), .module_irq_enable_in(me),
    .system_reset_out(sro), .reset_fetch_addr_out(fa), .peripherals_disable_out(pd), .pins_input_only_out(pio),
    .reset_source_register_out(rsr), .system_options_register_out(sor), .watchdog_count_out(wc),
    .low_voltage_detector_on_out(lon), .low_voltage_flag_out(lfl), .periodic_timer_flag_out(ptf),
    .periodic_timer_acknowledge_out(pta), .pending_wakeup_summary_out(sum), .wakeup_out(wk));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task tk(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  task chk(input string nm, input [13:0] e, input [13:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rel;
    integer i;
    begin
      for (i = 0; i < 99 && sro !== 1'b1; i = i + 1) tk(1);
      for (i = 0; i < 99 && sro !== 1'b0; i = i + 1) tk(1);
      chk("release", 0, sro);
      tk(2);
    end
  endtask
  task wopt(input [7:0] v);
    begin
      sow <= 1'b1;
      sod <= v;
      tk(1);
      sow <= 1'b0;
      tk(2);
    end
  endtask
  task ack(input v);
    begin
      ptw <= 1'b1;
      pack <= v;
      tk(1);
      ptw <= 1'b0;
      tk(2);
    end
  endtask
  task src(input integer n);
    begin
      case (n)
        0: illegal_opcode_reset <= 1'b1;
        1: illegal_address_reset <= 1'b1;
        2: rp_n <= 1'b0;
        default: dbgr <= 1'b1;
      endcase
      tk(5);
      chk("quiet", 1, pd & pio);
      {illegal_opcode_reset, illegal_address_reset, dbgr, rp_n} <= 4'h1;
      rel;
    end
  endtask
  task wflag;
    integer i;
    for (i = 0; i < 300 && ptf !== 1'b1; i = i + 1) tk(1);
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge er) ecnt = ecnt + 1;
  initial begin
    #200000;
    mismatches = mismatches + 1;
    stop_test;
  end
  initial begin
    {nrst_in, illegal_opcode_reset, illegal_address_reset, dbgr, bdm, stp, wt, srw, sow, lde, lse, lre, lie, lack} = 0;
    {ptw, pcs, pie, pack, brown, refrun, sod, per, mf, me} = 0;
    rp_n = 1'b1;
    image[14'h3FFD] = 8'hBC;
    image[14'h3FFE] = 8'h00;
    image[14'h3FFF] = 8'h00;
    {mismatches, total_checks, ecnt} = 0;
    tk(4);
    nrst_in <= 1'b1;
    rel;
    chk("fetch", 14'h3FFD, fa);
    chk("jump", 8'hBC, image[fa]);
    chk("srs", 8'h82, rsr);
    chk("opts", 8'hC0, sor);
    chk("quiet", 0, pd | pio);
    wopt(8'hC1);
    chk("opts", 8'hC1, sor);
    chk("wdog", 0, wc);
    wopt(8'h00);
    chk("opts", 8'hC1, sor);
    srw <= 1'b1;
    tk(1);
    srw <= 1'b0;
    tk(2);
    chk("srs", 8'h82, rsr);
    bdm <= 1'b1;
    tk(5);
    bdm <= 1'b0;
    for (k = 0; k < 4; k = k + 1) begin
      src(k);
      chk("srs", k == 0 ? 8'h10 : k == 1 ? 8'h08 : k == 2 ? 8'h40 : 8'h00, rsr);
      chk("opts", 8'hC1, sor);
    end
    lde <= 1'b1;
    lre <= 1'b1;
    brown <= 1'b1;
    tk(12);
    chk("hold", 1, sro);
    brown <= 1'b0;
    rel;
    chk("srs", 8'h02, rsr);
    lre <= 1'b0;
    lie <= 1'b1;
    wt <= 1'b1;
    brown <= 1'b1;
    tk(6);
    chk("lv flag", 1, lfl);
    chk("lv wake", 1, wk);
    chk("no reset", 0, sro);
    brown <= 1'b0;
    tk(4);
    lack <= 1'b1;
    tk(1);
    lack <= 1'b0;
    lie <= 1'b0;
    tk(3);
    chk("lv flag", 0, lfl);
    stp <= 1'b1;
    tk(3);
    chk("lvd on", 0, lon);
    lse <= 1'b1;
    tk(3);
    chk("lvd on", 1, lon);
    {stp, lse} <= 2'h0;
    mf <= 7'h08;
    tk(3);
    chk("sum", 7'h08, sum);
    chk("masked", 0, wk);
    me <= 7'h08;
    tk(3);
    chk("wake", 1, wk);
    wt <= 1'b0;
    tk(3);
    chk("run", 0, wk);
    mf <= 7'h00;
    tk(3);
    chk("sum", 0, sum);
    pcs <= 1'b1;
    refrun <= 1'b1;
    tk(150);
    chk("pt off", 0, ptf);
    per <= 3'h1;
    wflag;
    ecnt = 0;
    chk("pt flag", 1, ptf);
    {wt, pie} <= 2'h3;
    tk(3);
    chk("pt wake", 1, wk);
    pie <= 1'b0;
    tk(3);
    chk("pt mask", 0, wk);
    ack(1'b0);
    chk("pt flag", 1, ptf);
    ack(1'b1);
    chk("pt flag", 0, ptf);
    wflag;
    chk("edges", 8, ecnt);
    stop_test;
  end
endmodule // sysctl_top_tb
